/* File: verilog/smart_stby_map.svh */
// Task-file offsets, bit positions, codes and reset values
`ifndef SMART_STBY_MAP_SVH
`define SMART_STBY_MAP_SVH
`define TF_DATA        4'h0
`define TF_ERR_FEAT    4'h1
`define TF_COUNT       4'h2
`define TF_NUMBER      4'h3
`define TF_CYL_LO      4'h4
`define TF_CYL_HI      4'h5
`define TF_DEVHEAD     4'h6
`define TF_STAT_CMD    4'h7
`define TF_CONFIG      4'h8
`define TF_POWER       4'h9
`define ST_BSY         7
`define ST_DRDY        6
`define ST_DF          5
`define ST_DRQ         3
`define ST_ERR         0
`define ER_IDNF        4
`define ER_ABRT        2
`define DH_DEV         4
`define CFG_SMART_EN   0
`define CFG_WLOG_SUP   1
`define CFG_SAVE_SUP   2
`define CFG_PM_SUP     3
`define CFG_DEV_ID     4
`define CFG_IDNF       5
`define CFG_RESET      8'h0F
`define PWR_STANDBY    0
`define PWR_TMR_EN     1
`define CMD_SMART      8'hB0
`define CMD_STANDBY    8'hE2
`define FEAT_SAVE      8'hD3
`define FEAT_WLOG      8'hD6
`define SIG_LO         8'h4F
`define SIG_HI         8'hC2
`define LOG_DIR        8'h00
`define HV_LOG_FIRST   8'h80
`define HV_LOG_LAST    8'h9F
`define SECTOR_BYTES   512
`define BYTE_LAST      9'h1FF
`define STBY_TICK_MS   5000
`define CLK_KHZ        100000
`endif

/* File: verilog/smart_stby_pkg.sv */
// Types for the log and standby command block
package smart_stby_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_XFER = 2'b10
  } cmd_state_t;
  typedef logic [7:0] tf_byte_t;
  typedef logic [3:0] tf_addr_t;
endpackage

/* File: verilog/smart_stby_cmds.sv */
// Task-file command engine: save attributes, write log, standby
`timescale 1ns/1ps
`include "smart_stby_map.svh"

module smart_stby_cmds
  import smart_stby_pkg::*;
#(
  parameter int HV_LOG_SECTORS   = 4,
  parameter int STBY_TICK_CYCLES = `STBY_TICK_MS * `CLK_KHZ
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire smart_stby_pkg::tf_addr_t i_addr,
  input  wire smart_stby_pkg::tf_byte_t i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output      smart_stby_pkg::tf_byte_t o_rdata,
  input  wire logic                     i_dev_fault,
  output      logic                     o_attr_save,
  output      logic                     o_standby
);
  import smart_stby_pkg::*;

  localparam int HV_LOGS = 32;
  localparam int SEC_W   = (HV_LOG_SECTORS > 1) ? $clog2(HV_LOG_SECTORS) : 1;
  localparam int DEPTH   = HV_LOGS * HV_LOG_SECTORS * `SECTOR_BYTES;
  localparam int ADDR_W  = $clog2(DEPTH);
  localparam logic [7:0] DIR_SECTORS = 8'(HV_LOG_SECTORS);

  cmd_state_t state_reg;
  tf_byte_t   feat_reg, count_reg, number_reg, cyl_lo_reg, cyl_hi_reg;
  tf_byte_t   devhead_reg, cmd_reg, err_reg, cfg_reg, rdata_reg;
  logic       drdy_reg, df_reg, errbit_reg, save_reg, stby_reg, tmr_en_reg;
  logic       fault_meta_reg, fault_sync_reg;
  logic [8:0] byte_reg;
  logic [7:0] sec_reg, left_reg, period_reg, ticks_reg;
  logic [31:0] div_reg;
  tf_byte_t   log_mem [DEPTH];

  // Decoded strobes
  wire idle      = (state_reg == ST_IDLE);
  wire exec      = (state_reg == ST_EXEC);
  wire xfer      = (state_reg == ST_XFER);
  wire wr_tf     = i_wr && idle;
  wire wr_cmd    = wr_tf && (i_addr == `TF_STAT_CMD);
  wire wr_data   = i_wr && xfer && (i_addr == `TF_DATA);
  wire dev_sel   = (devhead_reg[`DH_DEV] == cfg_reg[`CFG_DEV_ID]);
  wire cmd_go    = wr_cmd && dev_sel;
  wire smart_en  = cfg_reg[`CFG_SMART_EN];
  wire is_smart  = (cmd_reg == `CMD_SMART);
  wire is_wlog   = is_smart && (feat_reg == `FEAT_WLOG);
  wire is_save   = is_smart && (feat_reg == `FEAT_SAVE);
  wire is_stby   = (cmd_reg == `CMD_STANDBY);
  wire sig_ok    = (cyl_lo_reg == `SIG_LO) && (cyl_hi_reg == `SIG_HI);
  wire log_hv    = (number_reg >= `HV_LOG_FIRST) && (number_reg <= `HV_LOG_LAST);
  wire log_ro    = (number_reg == `LOG_DIR);
  wire cnt_ok    = (count_reg != 8'h00) && (count_reg <= DIR_SECTORS);
  wire save_abt  = !cfg_reg[`CFG_SAVE_SUP] || !smart_en || !sig_ok;
  wire wlog_abt  = !cfg_reg[`CFG_WLOG_SUP] || !smart_en || !sig_ok || log_ro
                   || !log_hv || !cnt_ok;
  wire stby_abt  = !cfg_reg[`CFG_PM_SUP];
  wire cmd_abort = exec && ((is_save && save_abt) || (is_wlog && wlog_abt)
                   || (is_stby && stby_abt) || !(is_save || is_wlog || is_stby));
  wire save_ok   = exec && is_save && !save_abt;
  wire stby_ok   = exec && is_stby && !stby_abt;
  wire wlog_ok   = exec && is_wlog && !wlog_abt;
  wire sec_end   = wr_data && (byte_reg == `BYTE_LAST);
  wire idnf_hit  = sec_end && cfg_reg[`CFG_IDNF];
  wire last_sec  = sec_end && (left_reg == 8'h01);
  wire done_ok   = save_ok || stby_ok || (last_sec && !idnf_hit);
  wire done_err  = cmd_abort || idnf_hit;
  wire tick      = tmr_en_reg && (div_reg == 32'(STBY_TICK_CYCLES - 1));
  wire tmr_fire  = tick && !stby_reg && (ticks_reg == 8'h01);
  wire wake      = save_ok || wlog_ok;

  // sector index counts from the log start
  wire [7:0]        log_off  = number_reg - `HV_LOG_FIRST;
  wire [4:0]        log_idx  = log_off[4:0];
  wire [SEC_W-1:0]  sec_idx  = sec_reg[SEC_W-1:0];
  wire [ADDR_W-1:0] mem_addr = ADDR_W'((int'(log_idx) * HV_LOG_SECTORS + int'(sec_idx))
                               * `SECTOR_BYTES + int'(byte_reg));

  wire tf_byte_t status_val = {exec, drdy_reg, df_reg, 1'b0, xfer, 2'b00, errbit_reg};
  wire tf_byte_t power_val  = {6'h00, tmr_en_reg, stby_reg};
  wire tf_byte_t rd_mux =
    (i_addr == `TF_ERR_FEAT) ? err_reg     :
    (i_addr == `TF_COUNT)    ? count_reg   :
    (i_addr == `TF_NUMBER)   ? number_reg  :
    (i_addr == `TF_CYL_LO)   ? cyl_lo_reg  :
    (i_addr == `TF_CYL_HI)   ? cyl_hi_reg  :
    (i_addr == `TF_DEVHEAD)  ? devhead_reg :
    (i_addr == `TF_STAT_CMD) ? status_val  :
    (i_addr == `TF_CONFIG)   ? cfg_reg     :
    (i_addr == `TF_POWER)    ? power_val   : 8'h00;

  // Fault pin crosses in from outside the clock domain
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault_meta_reg <= 1'b0;
      fault_sync_reg <= 1'b0;
    end else begin
      fault_meta_reg <= i_dev_fault;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // Task-file shadows only change while idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      feat_reg    <= 8'h00;
      count_reg   <= 8'h00;
      number_reg  <= 8'h00;
      cyl_lo_reg  <= 8'h00;
      cyl_hi_reg  <= 8'h00;
      devhead_reg <= 8'h00;
      cmd_reg     <= 8'h00;
      cfg_reg     <= `CFG_RESET;
    end else if (wr_tf) begin
      case (i_addr)
        `TF_ERR_FEAT: feat_reg    <= i_wdata;
        `TF_COUNT:    count_reg   <= i_wdata;
        `TF_NUMBER:   number_reg  <= i_wdata;
        `TF_CYL_LO:   cyl_lo_reg  <= i_wdata;
        `TF_CYL_HI:   cyl_hi_reg  <= i_wdata;
        `TF_DEVHEAD:  devhead_reg <= i_wdata;
        `TF_STAT_CMD: cmd_reg     <= i_wdata;
        `TF_CONFIG:   cfg_reg     <= i_wdata;
        default:      cfg_reg     <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= cmd_go ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_reg <= wlog_ok ? ST_XFER : ST_IDLE;
        ST_XFER: state_reg <= (idnf_hit || last_sec) ? ST_IDLE : ST_XFER;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // sector and byte progress of the data-out
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      byte_reg <= 9'h000;
      sec_reg  <= 8'h00;
      left_reg <= 8'h00;
    end else if (wlog_ok) begin
      byte_reg <= 9'h000;
      sec_reg  <= 8'h00;
      left_reg <= count_reg;
    end else if (wr_data) begin
      byte_reg <= byte_reg + 9'h001;
      if (sec_end) begin
        sec_reg  <= sec_reg + 8'h01;
        left_reg <= left_reg - 8'h01;
      end
    end
  end

  // No reset: log contents are data, not control
  always_ff @(posedge i_clk) begin
    if (wr_data) begin
      log_mem[mem_addr] <= i_wdata;
    end
  end

  // Completion status; a pending fault wins only on error
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drdy_reg   <= 1'b1;
      df_reg     <= 1'b0;
      errbit_reg <= 1'b0;
      err_reg    <= 8'h00;
    end else if (done_err) begin
      drdy_reg   <= 1'b1;
      df_reg     <= fault_sync_reg;
      errbit_reg <= 1'b1;
      err_reg    <= 8'h00;
      err_reg[`ER_ABRT] <= cmd_abort;
      err_reg[`ER_IDNF] <= idnf_hit;
    end else if (done_ok) begin
      drdy_reg   <= 1'b1;
      df_reg     <= 1'b0;
      errbit_reg <= 1'b0;
      err_reg    <= 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      save_reg <= 1'b0;
    end else begin
      save_reg <= save_ok;
    end
  end

  // Tick divider keeps the timer on one clock
  always_ff @(posedge i_clk) begin
    if (i_rst || !tmr_en_reg || tick) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end

  // Period is in ticks; a new count replaces the old at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stby_reg   <= 1'b0;
      tmr_en_reg <= 1'b0;
      period_reg <= 8'h00;
      ticks_reg  <= 8'h00;
    end else if (stby_ok) begin
      stby_reg   <= 1'b1;
      tmr_en_reg <= (count_reg != 8'h00);
      period_reg <= count_reg;
      ticks_reg  <= count_reg;
    end else if (wake) begin
      stby_reg  <= 1'b0;
      ticks_reg <= period_reg;
    end else if (tmr_fire) begin
      stby_reg  <= 1'b1;
      ticks_reg <= period_reg;
    end else if (tick && !stby_reg) begin
      ticks_reg <= ticks_reg - 8'h01;
    end
  end

  assign o_rdata     = rdata_reg;
  assign o_attr_save = save_reg;
  assign o_standby   = stby_reg;

  sequence s_abort_shown;
    !exec && !xfer && err_reg[`ER_ABRT] && errbit_reg && drdy_reg;
  endsequence

  sequence s_clean_shown;
    drdy_reg && !errbit_reg && !df_reg && !exec && !xfer;
  endsequence

  property p_abort_flags;
    @(posedge i_clk) disable iff (i_rst) cmd_abort |=> s_abort_shown;
  endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("abort flags wrong");

  property p_save_sig;
    @(posedge i_clk) disable iff (i_rst) exec && is_save && !sig_ok |=> s_abort_shown;
  endproperty
  a_save_sig: assert property (p_save_sig) else $error("bad signature not aborted");

  property p_save_pulse;
    @(posedge i_clk) disable iff (i_rst) save_ok |=> o_attr_save ##1 !o_attr_save;
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save pulse wrong");

  property p_wlog_drq;
    @(posedge i_clk) disable iff (i_rst) wlog_ok |=> xfer && !exec;
  endproperty
  a_wlog_drq: assert property (p_wlog_drq) else $error("write-log did not raise DRQ");

  property p_wlog_count;
    @(posedge i_clk) disable iff (i_rst)
      exec && is_wlog && (count_reg > DIR_SECTORS) |=> s_abort_shown;
  endproperty
  a_wlog_count: assert property (p_wlog_count) else $error("oversize count taken");

  property p_wlog_ro;
    @(posedge i_clk) disable iff (i_rst) exec && is_wlog && log_ro |=> !xfer;
  endproperty
  a_wlog_ro: assert property (p_wlog_ro) else $error("read-only log written");

  property p_idnf;
    @(posedge i_clk) disable iff (i_rst)
      idnf_hit |=> err_reg[`ER_IDNF] && errbit_reg && idle;
  endproperty
  a_idnf: assert property (p_idnf) else $error("IDNF not reported");

  property p_clean;
    @(posedge i_clk) disable iff (i_rst) done_ok && !done_err |=> s_clean_shown;
  endproperty
  a_clean: assert property (p_clean) else $error("completion status wrong");

  property p_stby;
    @(posedge i_clk) disable iff (i_rst)
      stby_ok |=> o_standby && (tmr_en_reg == (count_reg != 8'h00))
                  && (period_reg == count_reg);
  endproperty
  a_stby: assert property (p_stby) else $error("standby entry wrong");

  property p_stby_abort;
    @(posedge i_clk) disable iff (i_rst)
      exec && is_stby && stby_abt && !o_standby |=> !o_standby && err_reg[`ER_ABRT];
  endproperty
  a_stby_abort: assert property (p_stby_abort) else $error("standby not aborted");

  property p_dev_sel;
    @(posedge i_clk) disable iff (i_rst) wr_cmd && !dev_sel |=> idle;
  endproperty
  a_dev_sel: assert property (p_dev_sel) else $error("other device command taken");

  sequence s_log_start;
    xfer && (mem_addr == ADDR_W'(int'(log_idx) * HV_LOG_SECTORS * `SECTOR_BYTES));
  endsequence

  property p_log_start;
    @(posedge i_clk) disable iff (i_rst) wlog_ok |=> s_log_start;
  endproperty
  a_log_start: assert property (p_log_start) else $error("log data not at first sector");

  property p_stby_cause;
    @(posedge i_clk) disable iff (i_rst)
      $rose(o_standby) |-> $past(stby_ok || (tick && (ticks_reg == 8'h01)));
  endproperty
  a_stby_cause: assert property (p_stby_cause) else $error("standby without cause");

  property p_busy_hold;
    @(posedge i_clk) disable iff (i_rst)
      i_wr && !idle |=> $stable(count_reg) && $stable(number_reg) && $stable(cfg_reg);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("task file changed while busy");

  property p_done_excl;
    @(posedge i_clk) disable iff (i_rst) !(done_ok && done_err);
  endproperty
  a_done_excl: assert property (p_done_excl) else $error("success and error together");
endmodule

/* File: verification/smart_host_model.sv */
// Host adapter model driving the task-file register port
`timescale 1ns/1ps
`include "smart_stby_map.svh"
module smart_host_model
  import smart_stby_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire smart_stby_pkg::tf_byte_t i_rdata,
  output      smart_stby_pkg::tf_addr_t o_addr,
  output      smart_stby_pkg::tf_byte_t o_wdata,
  output      logic                     o_wr,
  output      logic                     o_rd
);
  import smart_stby_pkg::*;
  initial begin
    o_addr  = 4'h0;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input tf_addr_t a, input tf_byte_t d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    // Released bus must not keep the last byte
    o_wdata <= ~d;
  endtask
  task automatic rd(input tf_addr_t a, output tf_byte_t d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    // Data stand in the cycle after the strobe
    @(posedge i_clk);
    d = i_rdata;
  endtask
  task automatic poll();
    tf_byte_t s;
    s = 8'h80;
    for (int i = 0; i < 20 && (s[`ST_BSY] || !s[`ST_DRDY]); i++) begin
      rd(`TF_STAT_CMD, s);
    end
  endtask
  task automatic cmd(input tf_byte_t f, c, n, lo, hi, dh, op);
    poll();
    wr(`TF_ERR_FEAT, f);
    wr(`TF_COUNT, c);
    wr(`TF_NUMBER, n);
    wr(`TF_CYL_LO, lo);
    wr(`TF_CYL_HI, hi);
    wr(`TF_DEVHEAD, dh);
    wr(`TF_STAT_CMD, op);
    poll();
  endtask
  task automatic data_out(input int sectors);
    for (int i = 0; i < sectors * `SECTOR_BYTES; i++) begin
      wr(`TF_DATA, i[7:0] ^ 8'h5A);
    end
  endtask
endmodule

/* File: verification/smart_log_and_standby_cmds_bench.sv */
// Self-checking bench for the log and standby command block
`timescale 1ns/1ps
`include "smart_stby_map.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module smart_log_and_standby_cmds_bench;
  import smart_stby_pkg::*;
  localparam int HV   = 2;
  localparam int TICK = 10;
  logic     i_clk       = 1'b0;
  logic     i_rst       = 1'b1;
  logic     i_dev_fault = 1'b0;
  tf_addr_t addr;
  tf_byte_t wdata;
  tf_byte_t rdata;
  tf_byte_t d;
  logic     wr_s;
  logic     rd_s;
  logic     attr_save;
  logic     standby;
  int       miscompares = 0;
  int       checks      = 0;
  int       cycles      = 0;
  int       saves       = 0;
  tf_byte_t sa_cf[5] = '{8'h0F, 8'h0F, 8'h0E, 8'h0B, 8'h0F};
  tf_byte_t sa_lo[5] = '{8'h4E, 8'h4F, 8'h4F, 8'h4F, 8'h4F};
  tf_byte_t sa_hi[5] = '{8'hC2, 8'hC3, 8'hC2, 8'hC2, 8'hC2};
  tf_byte_t sa_ft[5] = '{8'hD3, 8'hD3, 8'hD3, 8'hD3, 8'hD4};
  tf_byte_t wn[8] = '{8'h80, 8'h00, 8'h7F, 8'hA0, 8'h80, 8'h80, 8'h80, 8'h80};
  tf_byte_t wc[8] = '{tf_byte_t'(HV + 1), 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
  tf_byte_t wl[8] = '{8'h4F, 8'h4F, 8'h4F, 8'h4F, 8'h4F, 8'h4E, 8'h4F, 8'h4F};
  tf_byte_t wg[8] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0D, 8'h0E};

  smart_stby_cmds #(.HV_LOG_SECTORS(HV), .STBY_TICK_CYCLES(TICK)) u_smart_stby_cmds (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_dev_fault(i_dev_fault),
    .o_attr_save(attr_save), .o_standby(standby));
  smart_host_model u_smart_host_model (
    .i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr_s), .o_rd(rd_s));

  always #5 i_clk = ~i_clk;
  // Pulse counted at the falling edge, away from its launch
  always @(negedge i_clk) begin
    if (attr_save === 1'b1) saves++;
  end
  // Hang guard; the whole run needs well under this
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input tf_addr_t a, input tf_byte_t v);
    u_smart_host_model.wr(a, v);
  endtask
  task automatic cmd(input tf_byte_t f, c, n, lo, hi, dh, op);
    u_smart_host_model.cmd(f, c, n, lo, hi, dh, op);
  endtask
  task automatic chk_reg(input tf_addr_t a, input tf_byte_t e);
    u_smart_host_model.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic res(input tf_byte_t st, input tf_byte_t er);
    chk_reg(`TF_STAT_CMD, st);
    chk_reg(`TF_ERR_FEAT, er);
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    res(8'h40, 8'h00);
    chk_reg(`TF_CONFIG, `CFG_RESET);
    chk_reg(4'hF, 8'h00);
    cmd(`FEAT_SAVE, 8'h00, 8'h00, `SIG_LO, `SIG_HI, 8'h00, `CMD_SMART);
    `CHK(saves, 1)
    res(8'h40, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(`TF_CONFIG, sa_cf[k]);
      cmd(sa_ft[k], 8'h00, 8'h00, sa_lo[k], sa_hi[k], 8'h00, `CMD_SMART);
      res(8'h41, 8'h04);
    end
    `CHK(saves, 1)
    wr(`TF_CONFIG, 8'h0F);
    // Fault is synchronised, so raise it well ahead
    @(posedge i_clk) i_dev_fault <= 1'b1;
    cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    res(8'h61, 8'h04);
    @(posedge i_clk) i_dev_fault <= 1'b0;
    cmd(`FEAT_SAVE, 8'h00, 8'h00, `SIG_LO, `SIG_HI, 8'h00, `CMD_SMART);
    res(8'h40, 8'h00);
    for (int k = 0; k < 2; k++) begin
      cmd(`FEAT_WLOG, tf_byte_t'(k + 1), k ? `HV_LOG_LAST : `HV_LOG_FIRST, `SIG_LO,
          `SIG_HI, 8'h00, `CMD_SMART);
      res(8'h48, 8'h00);
      u_smart_host_model.data_out(k + 1);
      res(8'h40, 8'h00);
    end
    `CHK(u_smart_stby_cmds.log_mem[0], 8'h5A)
    `CHK(u_smart_stby_cmds.log_mem[`BYTE_LAST], 8'hA5)
    `CHK(u_smart_stby_cmds.log_mem[(31 * HV + 1) * `SECTOR_BYTES + 1], 8'h5B)
    for (int k = 0; k < 8; k++) begin
      wr(`TF_CONFIG, wg[k]);
      cmd(`FEAT_WLOG, wc[k], wn[k], wl[k], `SIG_HI, 8'h00, `CMD_SMART);
      res(8'h41, 8'h04);
    end
    wr(`TF_CONFIG, 8'h2F);
    cmd(`FEAT_WLOG, 8'h02, `HV_LOG_FIRST, `SIG_LO, `SIG_HI, 8'h00, `CMD_SMART);
    u_smart_host_model.data_out(1);
    res(8'h41, 8'h10);
    wr(`TF_CONFIG, 8'h07);
    cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `CMD_STANDBY);
    res(8'h41, 8'h04);
    `CHK(standby, 1'b0)
    wr(`TF_CONFIG, 8'h0F);
    cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `CMD_STANDBY);
    `CHK(standby, 1'b1)
    chk_reg(`TF_POWER, 8'h01);
    cmd(`FEAT_SAVE, 8'h00, 8'h00, `SIG_LO, `SIG_HI, 8'h00, `CMD_SMART);
    // Disabled timer must never expire
    repeat (40) @(posedge i_clk);
    `CHK(standby, 1'b0)
    cmd(8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h10, `CMD_STANDBY);
    `CHK(standby, 1'b0)
    res(8'h40, 8'h00);
    wr(`TF_CONFIG, 8'h1F);
    cmd(8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h10, `CMD_STANDBY);
    `CHK(standby, 1'b1)
    chk_reg(`TF_POWER, 8'h03);
    cmd(`FEAT_SAVE, 8'h00, 8'h00, `SIG_LO, `SIG_HI, 8'h10, `CMD_SMART);
    `CHK(standby, 1'b0)
    // Sampled just past the edge; expiry lands 21 to 30 cycles after wake
    repeat (18) @(posedge i_clk);
    #1 `CHK(standby, 1'b0)
    repeat (15) @(posedge i_clk);
    #1 `CHK(standby, 1'b1)
    wr(`TF_POWER, 8'h00);
    chk_reg(`TF_POWER, 8'h03);
    // Reset in mid-run must drop standby and the configuration
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    res(8'h40, 8'h00);
    chk_reg(`TF_POWER, 8'h00);
    chk_reg(`TF_CONFIG, `CFG_RESET);
    `CHK(standby, 1'b0)
    complete_run();
  end
endmodule
